// file: card_core_regs.svh
// Register offsets, field positions, reset values and timing of the card core
`ifndef CARD_CORE_REGS_SVH
`define CARD_CORE_REGS_SVH
`define OFS_INSN 8'h00
`define OFS_STATUS 8'h04
`define OFS_ACCB 8'h08
`define OFS_DSP 8'h0c
`define OFS_FLAGS 8'h10
`define OFS_PC 8'h14
`define OFS_RAMADR 8'h18
`define OFS_RAMDAT 8'h1c
`define OFS_E2ADR 8'h20
`define OFS_E2DAT 8'h24
`define OFS_LOCAL 8'h40
`define FLG_C 0
`define FLG_P 1
`define FLG_H 2
`define FLG_Z 3
`define STS_BUSY 0
`define STS_SIO 1
`define STS_DRIVE 2
`define RST_D 8'h00
`define RST_SP 8'hbf
`define MC_CLKS 4
`define CLK_MHZ 20
`define WRITE_TIME_US 10000
`define RAM_BYTES 192
`define ROM_BYTES 6144
`define E2_BYTES 8192
`define E2_BASE_HI 3'b010
`define PAGE_BYTES 32
`define STACK_BYTES 8
`define EWR_BYTE_ENTRY 16'h0f00
`define EWR_PAGE_ENTRY 16'h0f20
`define RT_MCYC 3
`endif

// file: card_core_pkg.sv
// Types of the card execution core
package card_core_pkg;
  typedef enum logic [7:0] {
    OP_NOP = 8'h00, OP_MOV_A_B = 8'h01, OP_MOV_A_D = 8'h02,
    OP_MOV_A_IND = 8'h03, OP_MOV_A_IMM = 8'h04, OP_MOV_A_RN = 8'h05,
    OP_MOV_B_A = 8'h06, OP_MOV_D_A = 8'h07, OP_MOV_IND_A = 8'h08,
    OP_MOV_N_A = 8'h09, OP_MOV_RN_A = 8'h0a, OP_MOV_D_IMM = 8'h0b,
    OP_MOV_RN_IMM = 8'h0c, OP_MOV_IND_E2 = 8'h0d, OP_XCH_A_B = 8'h0e,
    OP_XCH_A_IND = 8'h0f, OP_ADD_IND = 8'h10, OP_ADD_IMM = 8'h11,
    OP_ADC_IMM = 8'h12, OP_WORD_ADD_WITH_CARRY_N = 8'h13, OP_CMP_IMM = 8'h14,
    OP_EOR_IMM = 8'h15, OP_OR_IMM = 8'h16, OP_AND_IMM = 8'h17,
    OP_SIN = 8'h18, OP_SOUT = 8'h19, OP_EWR = 8'h1a
  } opcode_e;
  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_EXEC = 6'b000010,
    ST_LOAD = 6'b000100,
    ST_PROG = 6'b001000,
    ST_COMMIT = 6'b010000,
    ST_RET = 6'b100000
  } state_e;
endpackage : card_core_pkg

// file: card_core.sv
// Execution core of the card microcomputer with its nonvolatile write routine
`timescale 1ns/10ps
`include "card_core_regs.svh"

// How it works
// - Machine cycle equals four clock periods
// - Fully static, correct at any slower rate
// - Low reset input holds the reset state
// - Serial line released high during reset
// - Serial pin only pulled low or released
// - Map holds E2PROM, ROM and RAM sizes
// - E2PROM written only by write-call routines
// - E2PROM read copies (BA) into RAM(D)
// - Byte write equals page write, count one
// - Write takes about ten ms, then returns
// - Few stack bytes, registers and RAM kept
// - 32-byte pages, writes stay in page
// - Word add with carry from memory word
// - Call pushes return, entry selects mode
module card_core import card_core_pkg::*; #(
  parameter int WRITE_TIME_US = `WRITE_TIME_US,
  parameter int WRITE_CYCLES = WRITE_TIME_US * `CLK_MHZ
) (
  input wire logic core_clk, // Card clock
  input wire logic rst_n, // Reset, active low
  input wire logic wb_cyc_i, // Bus cycle
  input wire logic wb_stb_i, // Bus strobe
  input wire logic wb_we_i, // Bus write
  input wire logic [7:0] wb_adr_i, // Byte address
  input wire logic [3:0] wb_sel_i, // Byte lanes
  input wire logic [31:0] wb_dat_i, // Write data
  output logic [31:0] wb_dat_o, // Read data
  output logic wb_ack_o, // Bus acknowledge
  input wire logic sio_i, // Serial line level
  output logic sio_o, // Serial line drive value
  output logic sio_oe_n // Serial drive enable, low drives
);
  // ************************************************************
  // Storage
  // ************************************************************
  state_e st_q;
  logic [23:0] tmr_q;
  logic [23:0] insn_q;
  logic [7:0] a_q, b_q, d_q, sp_q;
  logic [15:0] pc_q;
  logic [3:0] flg_q;
  logic [7:0] r_q [8];
  logic [7:0] ram_q [`RAM_BYTES];
  logic [7:0] e2_q [`E2_BYTES];
  logic [7:0] pbuf_q [`PAGE_BYTES];
  logic [31:0] pmask_q;
  logic [5:0] k_q, cnt_q;
  logic [12:0] e2a_q;
  logic [7:0] ramadr_q;
  logic [12:0] e2adr_q;
  logic ack_q, sio_low_q;

  opcode_e op;
  logic [7:0] op1, op2;
  logic [15:0] ba, entry, ret;
  logic e2_ok, fin, wr, wr_idle;
  logic [5:0] tgt;
  logic [7:0] a_d, b_d, d_d, rn_d, ram_wa, ram_wd, addn;
  logic [3:0] flg_d;
  logic ram_we, rn_we, cin;
  logic [8:0] sum9;
  logic [4:0] sum5;
  logic [16:0] sum17;
  logic [31:0] rdat;

  function automatic logic [7:0] rd(input logic [7:0] adr);
    rd = (adr < 8'(`RAM_BYTES)) ? ram_q[adr] : 8'h00;
  endfunction : rd

  function automatic logic [2:0] mcyc(input logic [7:0] code);
    case (code)
      OP_MOV_A_IMM, OP_MOV_A_RN, OP_MOV_N_A, OP_MOV_RN_A, OP_MOV_D_IMM,
      OP_MOV_RN_IMM, OP_ADD_IMM, OP_ADC_IMM, OP_CMP_IMM, OP_EOR_IMM,
      OP_OR_IMM, OP_AND_IMM: mcyc = 3'd2;
      OP_MOV_IND_E2, OP_WORD_ADD_WITH_CARRY_N, OP_EWR: mcyc = 3'd4;
      default: mcyc = 3'd1;
    endcase
  endfunction : mcyc

  function automatic logic [15:0] ilen(input logic [7:0] code);
    case (code)
      OP_MOV_A_IMM, OP_MOV_N_A, OP_MOV_D_IMM, OP_MOV_RN_IMM, OP_ADD_IMM,
      OP_ADC_IMM, OP_WORD_ADD_WITH_CARRY_N, OP_CMP_IMM, OP_EOR_IMM, OP_OR_IMM,
      OP_AND_IMM, OP_EWR: ilen = 16'd2;
      default: ilen = 16'd1;
    endcase
  endfunction : ilen

  assign op = opcode_e'(insn_q[7:0]);
  assign op1 = insn_q[15:8];
  assign op2 = insn_q[23:16];
  assign ba = {b_q, a_q};
  assign entry = {op2, op1};
  assign ret = pc_q + 16'd2;
  // target must lie in the E2PROM window
  assign e2_ok = (ba[15:13] == `E2_BASE_HI);
  assign fin = (st_q == ST_EXEC) && (tmr_q == 24'd0);
  assign wr = wb_cyc_i && wb_stb_i && wb_we_i && ack_q && wb_sel_i[0];
  assign wr_idle = wr && (st_q == ST_IDLE);
  assign tgt = 6'(e2a_q[4:0]) + k_q;

  // ************************************************************
  // Instruction datapath
  // ************************************************************
  always_comb
  begin
    a_d = a_q;
    b_d = b_q;
    d_d = d_q;
    flg_d = flg_q;
    rn_d = a_q;
    rn_we = 1'b0;
    ram_we = 1'b0;
    ram_wa = d_q;
    ram_wd = a_q;
    sum9 = 9'd0;
    sum5 = 5'd0;
    sum17 = 17'd0;
    addn = 8'h00;
    cin = 1'b0;
    case (op)
      OP_MOV_A_B: a_d = b_q;
      OP_MOV_A_D: a_d = d_q;
      OP_MOV_A_IND: a_d = rd(d_q);
      OP_MOV_A_IMM: a_d = op1;
      OP_MOV_A_RN: a_d = r_q[op1[2:0]];
      OP_MOV_B_A: b_d = a_q;
      OP_MOV_D_A: d_d = a_q;
      OP_MOV_IND_A: ram_we = 1'b1;
      OP_MOV_N_A:
      begin
        ram_we = 1'b1;
        ram_wa = op1;
      end
      OP_MOV_RN_A: rn_we = 1'b1;
      OP_MOV_D_IMM: d_d = op1;
      OP_MOV_RN_IMM:
      begin
        rn_we = 1'b1;
        rn_d = op2;
      end
      // E2PROM read into RAM, flags kept
      OP_MOV_IND_E2:
      begin
        ram_we = 1'b1;
        ram_wd = e2_ok ? e2_q[ba[12:0]] : 8'h00;
      end
      OP_XCH_A_B:
      begin
        a_d = b_q;
        b_d = a_q;
      end
      OP_XCH_A_IND:
      begin
        a_d = rd(d_q);
        ram_we = 1'b1;
      end
      OP_ADD_IND, OP_ADD_IMM, OP_ADC_IMM:
      begin
        addn = (op == OP_ADD_IND) ? rd(d_q) : op1;
        cin = (op == OP_ADC_IMM) && flg_q[`FLG_C];
        sum9 = {1'b0, a_q} + {1'b0, addn} + {8'd0, cin};
        // Carry out of bit three gives half-carry
        sum5 = {1'b0, a_q[3:0]} + {1'b0, addn[3:0]} + {4'd0, cin};
        a_d = sum9[7:0];
        flg_d[`FLG_C] = sum9[8];
        flg_d[`FLG_H] = sum5[4];
      end
      // word add with carry, BA plus (N+1):(N)
      OP_WORD_ADD_WITH_CARRY_N:
      begin
        sum17 = {1'b0, ba} + {1'b0, rd(op1 + 8'd1), rd(op1)}
          + {16'd0, flg_q[`FLG_C]};
        a_d = sum17[7:0];
        b_d = sum17[15:8];
        flg_d[`FLG_C] = sum17[16];
        flg_d[`FLG_Z] = (sum17[15:0] == 16'd0);
      end
      OP_CMP_IMM:
      begin
        flg_d[`FLG_C] = (a_q < op1);
        flg_d[`FLG_Z] = (a_q == op1);
      end
      OP_EOR_IMM: a_d = a_q ^ op1;
      OP_OR_IMM: a_d = a_q | op1;
      OP_AND_IMM: a_d = a_q & op1;
      OP_SIN: flg_d[`FLG_C] = sio_i;
      default:
      begin
      end
    endcase
    case (op)
      OP_MOV_A_B, OP_MOV_A_D, OP_MOV_A_IND, OP_MOV_A_IMM, OP_MOV_A_RN,
      OP_XCH_A_B, OP_XCH_A_IND, OP_ADD_IND, OP_ADD_IMM, OP_ADC_IMM,
      OP_EOR_IMM, OP_OR_IMM, OP_AND_IMM: flg_d[`FLG_Z] = (a_d == 8'h00);
      default: flg_d[`FLG_Z] = flg_d[`FLG_Z];
    endcase
  end

  // ************************************************************
  // Sequencer
  // ************************************************************
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      st_q <= ST_IDLE;
      tmr_q <= 24'd0;
    end
    else
    begin
      case (st_q)
        ST_IDLE:
          if (wr_idle && wb_adr_i == `OFS_INSN)
          begin
            st_q <= ST_EXEC;
            tmr_q <= 24'(mcyc(wb_dat_i[7:0])) * 24'(`MC_CLKS) - 24'd1;
          end
        ST_EXEC:
          if (tmr_q != 24'd0)
            tmr_q <= tmr_q - 24'd1;
          else
            st_q <= (op == OP_EWR) ? ST_LOAD : ST_IDLE;
        // stop at count or page end
        ST_LOAD:
          if (k_q == cnt_q || tgt[5])
          begin
            st_q <= ST_PROG;
            tmr_q <= 24'(WRITE_CYCLES - 1);
          end
        ST_PROG:
          if (tmr_q != 24'd0)
            tmr_q <= tmr_q - 24'd1;
          else
            st_q <= ST_COMMIT;
        ST_COMMIT:
        begin
          st_q <= ST_RET;
          tmr_q <= 24'(`RT_MCYC * `MC_CLKS - 1);
        end
        ST_RET:
          if (tmr_q != 24'd0)
            tmr_q <= tmr_q - 24'd1;
          else
            st_q <= ST_IDLE;
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // ************************************************************
  // Write routine page buffer
  // ************************************************************
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      k_q <= 6'd0;
      cnt_q <= 6'd0;
      e2a_q <= 13'd0;
      pmask_q <= 32'd0;
    end
    else if (fin && op == OP_EWR)
    begin
      k_q <= 6'd0;
      pmask_q <= 32'd0;
      e2a_q <= ba[12:0];
      // byte routine is a page write of one
      if (!e2_ok)
        cnt_q <= 6'd0;
      else if (entry == `EWR_BYTE_ENTRY)
        cnt_q <= 6'd1;
      else if (entry == `EWR_PAGE_ENTRY)
        cnt_q <= (r_q[7] > 8'd32) ? 6'd32 : r_q[7][5:0];
      else
        cnt_q <= 6'd0;
    end
    else if (st_q == ST_LOAD && !(k_q == cnt_q || tgt[5]))
    begin
      // only this routine fills the page
      pbuf_q[tgt[4:0]] <= rd(d_q + 8'(k_q));
      pmask_q[tgt[4:0]] <= 1'b1;
      k_q <= k_q + 6'd1;
    end
  end

  // one program cycle for the page
  always_ff @(posedge core_clk)
  begin
    if (st_q == ST_COMMIT)
    begin
      for (int i = 0; i < `PAGE_BYTES; i++)
      begin
        if (pmask_q[i])
          e2_q[{e2a_q[12:5], 5'(i)}] <= pbuf_q[i];
      end
    end
  end

  // ************************************************************
  // Core registers
  // ************************************************************
  // static state flops
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      a_q <= 8'h00;
      b_q <= 8'h00;
      d_q <= `RST_D;
      flg_q <= 4'h0;
      for (int i = 0; i < 8; i++)
        r_q[i] <= 8'h00;
    end
    else if (fin)
    begin
      a_q <= a_d;
      b_q <= b_d;
      d_q <= d_d;
      flg_q <= flg_d;
      if (rn_we)
        r_q[op1[2:0]] <= rn_d;
    end
    else if (wr_idle)
    begin
      if (wb_adr_i == `OFS_ACCB)
        a_q <= wb_dat_i[7:0];
      if (wb_adr_i == `OFS_ACCB && wb_sel_i[1])
        b_q <= wb_dat_i[15:8];
      if (wb_adr_i == `OFS_DSP)
        d_q <= wb_dat_i[7:0];
      if (wb_adr_i == `OFS_FLAGS)
        flg_q <= wb_dat_i[3:0];
      if (wb_adr_i[7:5] == 3'b010 && wb_adr_i[1:0] == 2'b00)
        r_q[wb_adr_i[4:2]] <= wb_dat_i[7:0];
    end
  end

  // call pushes return, RT pops it
  // stack use well under eight bytes
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      pc_q <= 16'h0000;
      sp_q <= `RST_SP;
    end
    else if (fin && op == OP_EWR)
    begin
      pc_q <= entry;
      sp_q <= sp_q - 8'd2;
    end
    else if (fin)
      pc_q <= pc_q + ilen(op);
    else if (st_q == ST_RET && tmr_q == 24'd0)
    begin
      pc_q <= {rd(sp_q + 8'd2), rd(sp_q + 8'd1)};
      sp_q <= sp_q + 8'd2;
    end
    else if (wr_idle && wb_adr_i == `OFS_DSP && wb_sel_i[1])
      sp_q <= wb_dat_i[15:8];
    else if (wr_idle && wb_adr_i == `OFS_PC)
      pc_q <= {wb_sel_i[1] ? wb_dat_i[15:8] : pc_q[15:8], wb_dat_i[7:0]};
  end

  always_ff @(posedge core_clk)
  begin
    if (fin && op == OP_EWR)
    begin
      if (sp_q < 8'(`RAM_BYTES))
        ram_q[sp_q] <= ret[15:8];
      if (sp_q - 8'd1 < 8'(`RAM_BYTES))
        ram_q[sp_q - 8'd1] <= ret[7:0];
    end
    else if (fin && ram_we && ram_wa < 8'(`RAM_BYTES))
      ram_q[ram_wa] <= ram_wd;
    else if (wr_idle && wb_adr_i == `OFS_RAMDAT && ramadr_q < 8'(`RAM_BYTES))
      ram_q[ramadr_q] <= wb_dat_i[7:0];
  end

  // ************************************************************
  // Serial pin
  // ************************************************************
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      sio_low_q <= 1'b0;
    else if (fin && op == OP_SOUT)
      sio_low_q <= !flg_q[`FLG_C];
  end

  assign sio_o = 1'b0;
  assign sio_oe_n = !sio_low_q;

  // ************************************************************
  // Wishbone slave
  // ************************************************************
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      insn_q <= 24'd0;
      ramadr_q <= 8'h00;
      e2adr_q <= 13'd0;
    end
    else if (wr_idle)
    begin
      if (wb_adr_i == `OFS_INSN)
        insn_q <= wb_dat_i[23:0];
      if (wb_adr_i == `OFS_RAMADR)
        ramadr_q <= wb_dat_i[7:0];
      if (wb_adr_i == `OFS_E2ADR)
        e2adr_q <= wb_dat_i[12:0];
    end
  end

  always_comb
  begin
    rdat = 32'd0;
    case (wb_adr_i)
      `OFS_INSN: rdat = {8'd0, insn_q};
      `OFS_STATUS: rdat = {29'd0, sio_low_q, sio_i, st_q != ST_IDLE};
      `OFS_ACCB: rdat = {16'd0, b_q, a_q};
      `OFS_DSP: rdat = {16'd0, sp_q, d_q};
      `OFS_FLAGS: rdat = {28'd0, flg_q};
      `OFS_PC: rdat = {16'd0, pc_q};
      `OFS_RAMADR: rdat = {24'd0, ramadr_q};
      `OFS_RAMDAT: rdat = {24'd0, rd(ramadr_q)};
      `OFS_E2ADR: rdat = {19'd0, e2adr_q};
      `OFS_E2DAT: rdat = {24'd0, e2_q[e2adr_q]};
      default:
        if (wb_adr_i[7:5] == 3'b010 && wb_adr_i[1:0] == 2'b00)
          rdat = {24'd0, r_q[wb_adr_i[4:2]]};
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      ack_q <= 1'b0;
      wb_dat_o <= 32'd0;
    end
    else
    begin
      ack_q <= wb_cyc_i && wb_stb_i && !ack_q;
      if (wb_cyc_i && wb_stb_i && !ack_q)
        wb_dat_o <= rdat;
    end
  end

  assign wb_ack_o = ack_q;
endmodule : card_core

// file: card_core_fix_note_unused.sv
`timescale 1ns/10ps

// file: card_core_asserts.sv
// Port checker for the card execution core
`timescale 1ns/10ps
`include "card_core_regs.svh"
module card_core_asserts (
  input wire logic core_clk, // Card clock
  input wire logic rst_n, // Reset, active low
  input wire logic wb_cyc_i, // Bus cycle
  input wire logic wb_stb_i, // Bus strobe
  input wire logic wb_we_i, // Bus write
  input wire logic [7:0] wb_adr_i, // Byte address
  input wire logic [3:0] wb_sel_i, // Byte lanes
  input wire logic [31:0] wb_dat_i, // Write data
  input wire logic [31:0] wb_dat_o, // Read data
  input wire logic wb_ack_o, // Bus acknowledge
  input wire logic sio_i, // Line level
  input wire logic sio_o, // Line drive value
  input wire logic sio_oe_n // Drive enable, low drives
);
  // ****************************
  // Helper logic
  // ****************************
  logic [7:0] since_insn_q;
  logic req;
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  // Cycles since the last instruction write
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
      since_insn_q <= 8'hff;
    else if (wb_ack_o && wb_we_i && wb_adr_i == `OFS_INSN)
      since_insn_q <= 8'h00;
    else if (since_insn_q != 8'hff)
      since_insn_q <= since_insn_q + 8'h01;
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // ****************************
  // Properties
  // ****************************
  chk_rst_release: assert property (
    $rose(rst_n) |-> sio_oe_n && !wb_ack_o && wb_dat_o == 32'h0)
    else $error("state at reset release wrong");
  chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  chk_ack_prompt: assert property (req |=> wb_ack_o)
    else $error("ack missing after request");
  chk_ack_cause: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without request");
  chk_dat_hold: assert property (!(wb_cyc_i && wb_stb_i) |=> $stable(wb_dat_o))
    else $error("read data moved without request");
  chk_sio_low_only: assert property (!sio_oe_n |-> !sio_o)
    else $error("serial line driven high");
  chk_drive_status: assert property (
    req && !wb_we_i && wb_adr_i == `OFS_STATUS && $stable(sio_oe_n)
    |=> wb_dat_o[`STS_DRIVE] == !$past(sio_oe_n))
    else $error("drive status differs from line enable");
  chk_oe_cause: assert property ($changed(sio_oe_n) |-> since_insn_q <= 8'd8)
    else $error("line drive changed without instruction");
  cover property (req && wb_we_i && wb_adr_i == `OFS_INSN);
  cover property ($fell(sio_oe_n));
  cover property (req && !wb_we_i && wb_adr_i == `OFS_E2DAT);
endmodule : card_core_asserts

bind card_core card_core_asserts u_chk (
  .core_clk(core_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sio_i(sio_i), .sio_o(sio_o),
  .sio_oe_n(sio_oe_n)
);

// file: card_reader.sv
// Card reader model holding the shared serial line
`timescale 1ns/10ps
module card_reader (
  input wire logic pull_low, // Reader pulls line low
  input wire logic sio_o, // Card drive value
  input wire logic sio_oe_n, // Card drive enable, low drives
  output logic sio_line // Resolved line level
);
  assign sio_line = (pull_low || (!sio_oe_n && !sio_o)) ? 1'b0 : 1'b1;
endmodule : card_reader

// file: smart_card_cpu_eeprom_write_tb_top.sv
// Self-checking bench for the card execution core
`timescale 1ns/10ps
`include "card_core_regs.svh"
module smart_card_cpu_eeprom_write_tb_top import card_core_pkg::*;;
  // ****************************
  // Signals and instances
  // ****************************
  localparam int WCYC = 20;
  localparam int LIMIT = 20000;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, pull_low = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
  logic wb_ack_o, sio_o, sio_oe_n, sio_line;
  int n_mismatch = 0;
  int compares = 0;
  int cycles = 0;
  int nb1, nb4;
  localparam logic [79:0] ROWS [28] = '{
    {`OFS_INSN, 24'h0, OP_MOV_A_IMM, `OFS_FLAGS, 32'h8},
    {`OFS_INSN, 16'h0, 8'h80, OP_MOV_A_IMM, `OFS_FLAGS, 32'h0},
    {`OFS_INSN, 24'h0, OP_MOV_B_A, `OFS_ACCB, 32'h8080},
    {`OFS_INSN, 16'h0, 8'h80, OP_ADD_IMM, `OFS_FLAGS, 32'h9},
    {`OFS_INSN, 16'h0, 8'h0f, OP_MOV_A_IMM, `OFS_FLAGS, 32'h1},
    {`OFS_INSN, 16'h0, 8'h01, OP_ADD_IMM, `OFS_FLAGS, 32'h4},
    {`OFS_INSN, 16'h0, 8'hf0, OP_ADC_IMM, `OFS_FLAGS, 32'h9},
    {`OFS_INSN, 24'h0, OP_ADC_IMM, `OFS_ACCB, 32'h8001},
    {`OFS_INSN, 16'h0, 8'h02, OP_CMP_IMM, `OFS_FLAGS, 32'h1},
    {`OFS_INSN, 24'h0, OP_MOV_D_A, `OFS_DSP, 32'hbf01},
    {`OFS_INSN, 24'h0, OP_XCH_A_B, `OFS_ACCB, 32'h0180},
    {`OFS_RAMADR, 32'h10, `OFS_RAMADR, 32'h10},
    {`OFS_RAMDAT, 32'hff, `OFS_RAMDAT, 32'hff},
    {`OFS_RAMADR, 32'h11, `OFS_RAMADR, 32'h11},
    {`OFS_RAMDAT, 32'h7f, `OFS_RAMDAT, 32'h7f},
    {`OFS_INSN, 16'h0, 8'h10, OP_WORD_ADD_WITH_CARRY_N, `OFS_ACCB, 32'h8180},
    {`OFS_INSN, 24'h0, OP_NOP, `OFS_FLAGS, 32'h0},
    {`OFS_INSN, 16'h0, 8'hff, OP_EOR_IMM, `OFS_ACCB, 32'h817f},
    {`OFS_INSN, 24'h0, OP_AND_IMM, `OFS_FLAGS, 32'h8},
    {`OFS_INSN, 16'h0, 8'h3c, OP_OR_IMM, `OFS_ACCB, 32'h813c},
    {`OFS_INSN, 24'h0, OP_MOV_A_D, `OFS_ACCB, 32'h8101},
    {`OFS_INSN, 16'h0, 8'h07, OP_MOV_RN_A, `OFS_LOCAL + 8'h1c, 32'h1},
    {`OFS_INSN, 16'h0, 8'h10, OP_MOV_D_IMM, `OFS_DSP, 32'hbf10},
    {`OFS_INSN, 24'h0, OP_MOV_A_IND, `OFS_ACCB, 32'h81ff},
    {`OFS_INSN, 24'h0, OP_ADD_IND, `OFS_FLAGS, 32'h5},
    {`OFS_INSN, 16'h0, 8'h07, OP_MOV_A_RN, `OFS_ACCB, 32'h8101},
    {`OFS_INSN, 24'h0, OP_XCH_A_IND, `OFS_ACCB, 32'h81ff},
    {`OFS_INSN, 16'h0, 8'h11, OP_MOV_N_A, `OFS_RAMDAT, 32'hff}
  };
  always #25 core_clk = ~core_clk;
  card_core #(.WRITE_CYCLES(WCYC)) u_dut (
    .core_clk(core_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sio_i(sio_line), .sio_o(sio_o),
    .sio_oe_n(sio_oe_n)
  );
  card_reader u_reader (.pull_low(pull_low), .sio_o(sio_o), .sio_oe_n(sio_oe_n),
    .sio_line(sio_line));
  // ****************************
  // Tasks
  // ****************************
  task automatic summarize;
    $display("Compares %0d, mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : summarize
  task automatic chk_word(input string name, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk_word
  task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] wd);
    @(posedge core_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_sel_i <= 4'hf;
    wb_dat_i <= wd;
    do
      @(posedge core_clk);
    while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask : wb_xfer
  task automatic wr(input logic [7:0] adr, input logic [31:0] wd);
    wb_xfer(1'b1, adr, wd);
  endtask : wr
  task automatic rd_chk(input string name, input logic [7:0] adr, input logic [31:0] exp);
    wb_xfer(1'b0, adr, 32'h0);
    chk_word(name, exp, rd);
  endtask : rd_chk
  task automatic wait_idle(output int nb);
    nb = 0;
    do
    begin
      wb_xfer(1'b0, `OFS_STATUS, 32'h0);
      nb++;
    end
    while (rd[`STS_BUSY] !== 1'b0);
  endtask : wait_idle
  task automatic run(input logic [31:0] insn);
    int nb;
    wr(`OFS_INSN, insn);
    wait_idle(nb);
  endtask : run
  task automatic ram_wr(input logic [7:0] a, input logic [7:0] v);
    wr(`OFS_RAMADR, {24'h0, a});
    wr(`OFS_RAMDAT, {24'h0, v});
  endtask : ram_wr
  task automatic e2_chk(input logic [12:0] idx, input logic [7:0] exp);
    wr(`OFS_E2ADR, {19'h0, idx});
    rd_chk("e2 data", `OFS_E2DAT, {24'h0, exp});
  endtask : e2_chk
  // Stage BA and D, call the write routine, check what it must keep
  task automatic nonvolatile_write_call(input logic [15:0] ba, input logic [7:0] d, input logic [15:0] entry);
    logic [31:0] pc0;
    int nb;
    run({16'h0, ba[15:8], OP_MOV_A_IMM});
    run({24'h0, OP_MOV_B_A});
    run({16'h0, ba[7:0], OP_MOV_A_IMM});
    run({16'h0, d, OP_MOV_D_IMM});
    wb_xfer(1'b0, `OFS_PC, 32'h0);
    pc0 = rd;
    wr(`OFS_INSN, {8'h0, entry, OP_EWR});
    wait_idle(nb);
    chk_word("write time", 32'h1, {31'h0, nb * 3 > WCYC + 16});
    rd_chk("pc return", `OFS_PC, pc0 + 32'h2);
    rd_chk("sp and d", `OFS_DSP, {16'h0, `RST_SP, d});
    rd_chk("ba kept", `OFS_ACCB, {16'h0, ba});
  endtask : nonvolatile_write_call
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == LIMIT)
    begin
      n_mismatch++;
      summarize();
    end
  end
  // ****************************
  // Main sequence
  // ****************************
  initial
  begin
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    rd_chk("unmapped", 8'h80, 32'h0);
    rd_chk("reset dsp", `OFS_DSP, {16'h0, `RST_SP, `RST_D});
    foreach (ROWS[i])
    begin
      wr(ROWS[i][79:72], ROWS[i][71:40]);
      if (ROWS[i][79:72] == `OFS_INSN)
        wait_idle(nb1);
      rd_chk($sformatf("row %0d", i), ROWS[i][39:32], ROWS[i][31:0]);
    end
    ram_wr(8'h20, 8'h5a);
    run({8'h0, 8'h03, 8'h07, OP_MOV_RN_IMM});
    nonvolatile_write_call(16'h4040, 8'h20, `EWR_BYTE_ENTRY);
    e2_chk(13'h0040, 8'h5a);
    ram_wr(8'h40, 8'h11);
    ram_wr(8'h41, 8'h22);
    ram_wr(8'h42, 8'h33);
    nonvolatile_write_call(16'h403e, 8'h40, `EWR_PAGE_ENTRY);
    e2_chk(13'h003e, 8'h11);
    e2_chk(13'h003f, 8'h22);
    e2_chk(13'h0040, 8'h5a);
    rd_chk("ram kept", `OFS_RAMDAT, 32'h33);
    repeat (40) @(posedge core_clk);
    rd_chk("state held", `OFS_ACCB, 32'h403e);
    wr(`OFS_RAMADR, 32'hc0);
    wr(`OFS_RAMDAT, 32'h5a);
    rd_chk("ram top", `OFS_RAMDAT, 32'h0);
    run({16'h0, 8'h50, OP_MOV_D_IMM});
    wr(`OFS_INSN, {24'h0, OP_MOV_IND_E2});
    wait_idle(nb4);
    wr(`OFS_RAMADR, 32'h50);
    rd_chk("e2 to ram", `OFS_RAMDAT, 32'h11);
    wr(`OFS_INSN, {24'h0, OP_NOP});
    wait_idle(nb1);
    chk_word("busy reads", 32'h4, 32'(nb4 - nb1));
    ram_wr(8'h20, 8'ha5);
    nonvolatile_write_call(16'h2040, 8'h20, `EWR_BYTE_ENTRY);
    e2_chk(13'h0040, 8'h5a);
    run({24'h0, OP_SIN});
    wb_xfer(1'b0, `OFS_FLAGS, 32'h0);
    chk_word("carry high", 32'h1, {31'h0, rd[`FLG_C]});
    run({24'h0, OP_SOUT});
    chk_word("line released", 32'h1, {31'h0, sio_line});
    pull_low <= 1'b1;
    run({24'h0, OP_SIN});
    pull_low <= 1'b0;
    wb_xfer(1'b0, `OFS_FLAGS, 32'h0);
    chk_word("carry low", 32'h0, {31'h0, rd[`FLG_C]});
    run({24'h0, OP_SOUT});
    chk_word("line pulled", 32'h0, {31'h0, sio_line});
    rd_chk("status low", `OFS_STATUS, 32'h4);
    rst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    chk_word("line in reset", 32'h1, {31'h0, sio_line});
    rst_n <= 1'b1;
    rd_chk("accb reset", `OFS_ACCB, 32'h0);
    rd_chk("status idle", `OFS_STATUS, 32'h2);
    summarize();
  end
endmodule : smart_card_cpu_eeprom_write_tb_top
